// File: logic/sram_ctl_regs.vh
`ifndef SRAM_CTL_REGS_VH
`define SRAM_CTL_REGS_VH
// ----------------------------------------
// timing, ns and 200 MHz cycles
// ----------------------------------------
`define CLK_PERIOD_NS 5
`define READ_CYCLE_MIN_NS 40
`define ADDR_TO_DATA_DELAY_NS 40
`define SELECT_TO_DATA_DELAY_NS 40
`define WRITE_CYCLE_MIN_NS 40
`define SELECT_TO_WRITE_END_NS 37
`define ADDR_TO_WRITE_END_NS 37
`define WRITE_PULSE_MIN_NS 23
`define DATA_TO_WRITE_END_NS 23
`define WRITE_TO_HIGHZ_NS 22
`define RETENTION_ENTRY_DELAY_NS 0
// least times round up, margin of two sync cycles added to the access time for data
`define CEIL_CYC(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define READ_CYC (`CEIL_CYC(`READ_CYCLE_MIN_NS))
`define ACCESS_CYC (`CEIL_CYC(`ADDR_TO_DATA_DELAY_NS))
`define WP_CYC (`CEIL_CYC(`WRITE_PULSE_MIN_NS))
`define WCYC_CYC (`CEIL_CYC(`WRITE_CYCLE_MIN_NS))
`define HIGHZ_CYC (`CEIL_CYC(`WRITE_TO_HIGHZ_NS))
`define ADDR_W 16
`endif

// File: logic/sram_cycle_timer.v
`timescale 1ns/100ps
`include "sram_ctl_regs.vh"
// ----------------------------------------
// down counter timing each phase
// ----------------------------------------
module sram_cycle_timer #(
  parameter W = 8
) (
  input wire sys_clk_in,
  input wire rst_n_in,
  input wire load_in,
  input wire [W-1:0] count_in,
  output wire done_out
);
  reg [W-1:0] cnt_q;
  always @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      cnt_q <= {W{1'b0}};
    end else if (load_in) begin
      cnt_q <= count_in;
    end else if (cnt_q != {W{1'b0}}) begin
      cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
    end
  end
  // raw zero only: the sequencer's load is built from this, so no path runs back from load
  assign done_out = (cnt_q == {W{1'b0}});
endmodule // sram_cycle_timer

// File: logic/sram_ctl.v
`timescale 1ns/100ps
`include "sram_ctl_regs.vh"
// ----------------------------------------
// host controller for the 64k x 1 static ram
// ----------------------------------------
module sram_ctl #(
  parameter AW = `ADDR_W,
  parameter READ_CYC = `READ_CYC,
  parameter ACCESS_CYC = `ACCESS_CYC,
  parameter WP_CYC = `WP_CYC,
  parameter WCYC_CYC = `WCYC_CYC,
  parameter HIGHZ_CYC = `HIGHZ_CYC
) (
  input wire sys_clk_in,
  input wire rst_n_in,
  input wire req_valid_in,
  input wire req_write_in,
  input wire [AW-1:0] req_addr_in,
  input wire req_wdata_in,
  output wire req_ready_out,
  output reg rsp_valid_out,
  output reg rsp_rdata_out,
  input wire retain_in,
  output wire retained_out,
  output reg [AW-1:0] word_select_lines_out,
  output reg din_out,
  output reg chip_select_n_out,
  output reg write_enable_n_out,
  input wire dout_in
);
  // ----------------------------------------
  // states
  // ----------------------------------------
  localparam [2:0] S_IDLE = 3'd0;
  localparam [2:0] S_READ = 3'd1;
  localparam [2:0] S_WRITE = 3'd2;
  localparam [2:0] S_WREC = 3'd3;
  localparam [2:0] S_RETAIN = 3'd4;
  localparam [2:0] S_RECOVER = 3'd5;
  // ----------------------------------------
  // phase lengths in clock cycles
  // ----------------------------------------
  // counts worked out at 32 bits, then narrowed on purpose to the timer width
  localparam [31:0] READ_CYC_W = READ_CYC;
  localparam [31:0] ACC_CYC_W = ACCESS_CYC + 2;
  localparam [31:0] RD_CYC_W = (ACC_CYC_W > READ_CYC_W) ? ACC_CYC_W : READ_CYC_W;
  localparam [31:0] WP_CYC_W = (WP_CYC > WCYC_CYC) ? WP_CYC : WCYC_CYC;
  localparam [31:0] HZ_CYC_W = HIGHZ_CYC;
  // read select covers access plus two sync stages, never below the read cycle
  localparam [7:0] READ_CNT = READ_CYC_W[7:0];
  localparam [7:0] RD_CNT = RD_CYC_W[7:0];
  localparam [7:0] WP_CNT = WP_CYC_W[7:0];
  localparam [7:0] HZ_CNT = HZ_CYC_W[7:0];

  // ----------------------------------------
  // registers and wires
  // ----------------------------------------
  reg [2:0] state_q;
  wire [1:0] pin_raw;
  wire [1:0] pin_sync;
  wire dout_sync_q;
  wire retain_sync_q;
  reg load;
  reg [7:0] load_val;
  wire tdone;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  // bit 0 carries the ram output, bit 1 the retention request
  assign pin_raw = {retain_in, dout_in};
  assign dout_sync_q = pin_sync[0];
  assign retain_sync_q = pin_sync[1];
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_sync
      // two stages per pin; only the second stage is read
      reg meta_q;
      reg sync_q;
      always @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
          meta_q <= 1'b0;
          sync_q <= 1'b0;
        end else begin
          meta_q <= pin_raw[gi];
          sync_q <= meta_q;
        end
      end
      assign pin_sync[gi] = sync_q;
    end
  endgenerate

  // ----------------------------------------
  // phase timer
  // ----------------------------------------
  // one timer serves every phase; it reads zero once the phase has run out
  sram_cycle_timer #(
    .W(8)
  ) u_timer (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .load_in(load),
    .count_in(load_val),
    .done_out(tdone)
  );

  // ----------------------------------------
  // handshake outputs
  // ----------------------------------------
  // no request is taken while a retention request is pending
  assign req_ready_out = (state_q == S_IDLE) && !retain_sync_q;
  assign retained_out = (state_q == S_RETAIN);

  // ----------------------------------------
  // timer loading
  // ----------------------------------------
  always @* begin
    load = 1'b0;
    load_val = 8'h00;
    case (state_q)
      S_IDLE: begin
        if (retain_sync_q) begin
          load = 1'b0;
        end else if (req_valid_in) begin
          load = 1'b1;
          // read select spans access time and both sync stages
          load_val = req_write_in ? WP_CNT : RD_CNT;
        end
      end
      S_WRITE: begin
        if (tdone) begin
          load = 1'b1;
          load_val = HZ_CNT;
        end
      end
      S_RETAIN: begin
        if (!retain_sync_q) begin
          load = 1'b1;
          load_val = READ_CNT;
        end
      end
      default: begin
        load = 1'b0;
      end
    endcase
  end

  // ----------------------------------------
  // cycle sequencer
  // ----------------------------------------
  always @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      state_q <= S_IDLE;
      word_select_lines_out <= {AW{1'b0}};
      din_out <= 1'b0;
      chip_select_n_out <= 1'b1;
      write_enable_n_out <= 1'b1;
      rsp_valid_out <= 1'b0;
      rsp_rdata_out <= 1'b0;
    end else begin
      rsp_valid_out <= 1'b0;
      case (state_q)
        S_IDLE: begin
          if (retain_sync_q) begin
            chip_select_n_out <= 1'b1;
            write_enable_n_out <= 1'b1;
            state_q <= S_RETAIN;
          end else if (req_valid_in) begin
            // address and data set up with the strobes: zero setup allowed
            word_select_lines_out <= req_addr_in;
            din_out <= req_wdata_in;
            chip_select_n_out <= 1'b0;
            write_enable_n_out <= !req_write_in;
            state_q <= req_write_in ? S_WRITE : S_READ;
          end
        end
        S_READ: begin
          if (tdone) begin
            rsp_valid_out <= 1'b1;
            // bit taken two sync stages after it settled on the pin
            rsp_rdata_out <= dout_sync_q;
            chip_select_n_out <= 1'b1;
            state_q <= S_IDLE;
          end
        end
        S_WRITE: begin
          if (tdone) begin
            // both strobes rise together, address held until after
            write_enable_n_out <= 1'b1;
            chip_select_n_out <= 1'b1;
            state_q <= S_WREC;
          end
        end
        S_WREC: begin
          // hold off the next select until the output has floated
          if (tdone) begin
            rsp_valid_out <= 1'b1;
            state_q <= S_IDLE;
          end
        end
        S_RETAIN: begin
          // select stays high for as long as retention is asked for
          chip_select_n_out <= 1'b1;
          write_enable_n_out <= 1'b1;
          if (!retain_sync_q) begin
            state_q <= S_RECOVER;
          end
        end
        S_RECOVER: begin
          // rest for one read cycle before the next access
          if (tdone) begin
            state_q <= S_IDLE;
          end
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end
endmodule // sram_ctl

// File: verif/sram_ctl_sva.sv
`timescale 1ns/100ps
// ------------------------------
// strobe and answer timing
// ------------------------------
module sram_ctl_sva #(parameter AW = 16) (
  input wire sys_clk_in,
  input wire rst_n_in,
  input wire req_valid_in,
  input wire req_write_in,
  input wire req_ready_out,
  input wire rsp_valid_out,
  input wire retained_out,
  input wire [AW-1:0] word_select_lines_out,
  input wire din_out,
  input wire chip_select_n_out,
  input wire write_enable_n_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  read_len_a: assert property ($fell(chip_select_n_out) && write_enable_n_out
    |-> !chip_select_n_out [*8]) else $error("read select too short");
  write_len_a: assert property ($fell(write_enable_n_out)
    |-> (!chip_select_n_out && !write_enable_n_out) [*8]) else $error("write pulse too short");
  we_sel_a: assert property (!write_enable_n_out |-> !chip_select_n_out)
    else $error("write strobe without select");
  addr_hold_a: assert property (!chip_select_n_out && $past(!chip_select_n_out)
    |-> $stable(word_select_lines_out)) else $error("address moved in access");
  din_hold_a: assert property (!write_enable_n_out && $past(!write_enable_n_out)
    |-> $stable(din_out)) else $error("input bit moved in write");
  end_both_a: assert property ($rose(write_enable_n_out) |-> $rose(chip_select_n_out))
    else $error("write end not on both strobes");
  retain_sel_a: assert property (retained_out |-> chip_select_n_out && !req_ready_out)
    else $error("access during retention");
  read_rsp_a: assert property (req_valid_in && req_ready_out && !req_write_in
    |-> ##[8:12] rsp_valid_out) else $error("read answer late");
  write_rsp_a: assert property (req_valid_in && req_ready_out && req_write_in
    |-> ##[9:16] rsp_valid_out) else $error("write answer late");
endmodule // sram_ctl_sva
bind sram_ctl sram_ctl_sva #(.AW(AW)) chk (.sys_clk_in, .rst_n_in, .req_valid_in,
  .req_write_in, .req_ready_out, .rsp_valid_out, .retained_out, .word_select_lines_out,
  .din_out, .chip_select_n_out, .write_enable_n_out);

// File: verif/sram_model.sv
`timescale 1ns/100ps
// ------------------------------
// behavioural 64k x 1 ram
// ------------------------------
module sram_model #(parameter ACC_NS = 35) (
  input wire [15:0] addr_in,
  input wire din_in,
  input wire cs_n_in,
  input wire we_n_in,
  output reg dout_out
);
  reg mem [0:65535];
  initial dout_out = 1'b0;
  always @* if (!cs_n_in && !we_n_in) mem[addr_in] = din_in;
  // floating output shows a toggling level, never a stale bit
  always @(addr_in or cs_n_in or we_n_in or din_in) begin
    if (cs_n_in || !we_n_in) dout_out <= #22 ~dout_out;
    else dout_out <= #(ACC_NS) mem[addr_in];
  end
endmodule // sram_model

// File: verif/tb_async_sram_64k_x1_access.sv
`timescale 1ns/100ps
module tb_async_sram_64k_x1_access;
  reg sys_clk_in = 0, rst_n_in = 0, req_valid_in = 0, req_write_in = 0;
  reg req_wdata_in = 0, retain_in = 0;
  reg [15:0] req_addr_in = 16'h0000;
  wire req_ready_out, rsp_valid_out, rsp_rdata_out, retained_out, din_out, dout_in;
  wire chip_select_n_out, write_enable_n_out;
  wire [15:0] word_select_lines_out;
  reg ref_mem [0:65535];
  reg [31:0] r;
  integer seed = 32'hae8e1db6, err_total = 0, tests_run = 0, cyc = 0, i, n;
  sram_ctl uut (.sys_clk_in, .rst_n_in, .req_valid_in, .req_write_in, .req_addr_in,
    .req_wdata_in, .req_ready_out, .rsp_valid_out, .rsp_rdata_out, .retain_in, .retained_out,
    .word_select_lines_out, .din_out, .chip_select_n_out, .write_enable_n_out, .dout_in);
  sram_model #(.ACC_NS(40)) ram (.addr_in(word_select_lines_out), .din_in(din_out),
    .cs_n_in(chip_select_n_out), .we_n_in(write_enable_n_out), .dout_out(dout_in));
  initial forever #2.5 sys_clk_in = ~sys_clk_in;
  task wrap_up;
    begin
      $display("errors %0d checks %0d", err_total, tests_run);
      if (err_total == 0 && tests_run > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
    end
  endtask
  always @(posedge sys_clk_in) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      err_total = err_total + 1;
      wrap_up;
    end
  end
  task check(input logic seen, input logic exp);
    begin
      tests_run = tests_run + 1;
      if (seen !== exp) begin
        err_total = err_total + 1;
        $display("wrong value at %0t: saw %b expected %b", $time, seen, exp);
      end
    end
  endtask
  // cycles from take edge to answer: read 8 access + 2 sync + 1, write 8 pulse + 5 float + 2
  function integer resp_cycles(input logic w);
    resp_cycles = w ? 15 : 11;
  endfunction
  task xfer(input logic w, input logic [15:0] ad, input logic d);
    begin
      @(posedge sys_clk_in) #1;
      req_valid_in = 1; req_write_in = w; req_addr_in = ad; req_wdata_in = d;
      while (req_ready_out !== 1'b1) @(posedge sys_clk_in) #1;
      @(posedge sys_clk_in) #1;
      req_valid_in = 0;
      n = 0;
      while (rsp_valid_out !== 1'b1 && n < 40) begin
        @(posedge sys_clk_in) #1;
        n = n + 1;
      end
      check(n < 40, 1'b1);
      check(n == resp_cycles(w), 1'b1);
      if (!w) check(rsp_rdata_out, ref_mem[ad]);
      else ref_mem[ad] = d;
    end
  endtask
  initial begin
    repeat (2) @(posedge sys_clk_in);
    #1 rst_n_in = 1;
    check(chip_select_n_out, 1'b1);
    xfer(1, 16'hffff, 1); xfer(1, 16'h0000, 0); xfer(0, 16'hffff, 0); xfer(0, 16'h0000, 0);
    xfer(1, 16'hffff, 0); xfer(0, 16'hffff, 0);
    for (i = 0; i < 16; i = i + 1) begin
      r = $random(seed);
      xfer(1, i[15:0], r[0]);
    end
    for (i = 0; i < 80; i = i + 1) begin
      r = $random(seed);
      xfer(r[0], {12'h000, r[11:8]}, r[16]);
    end
    @(posedge sys_clk_in) #1 retain_in = 1;
    repeat (6) @(posedge sys_clk_in);
    #1 check(retained_out, 1'b1);
    check(chip_select_n_out, 1'b1);
    check(req_ready_out, 1'b0);
    retain_in = 0;
    n = 0;
    while (req_ready_out !== 1'b1 && n < 40) begin
      @(posedge sys_clk_in) #1;
      n = n + 1;
    end
    check(n >= 8 && n < 40, 1'b1);
    xfer(0, 16'hffff, 0);
    wrap_up;
  end
endmodule // tb_async_sram_64k_x1_access
